// [core/ufc_consts.vh]
// ufc_consts.vh: register offsets, field positions, reset values and counts
// for the fifo control block; definitions only
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH

`define UFC_OFF_FIFO_CONTROL 4'h0
`define UFC_OFF_STATUS       4'h4
`define UFC_OFF_INT_STATUS   4'h8
`define UFC_OFF_INT_MASK     4'hc

`define UFC_FC_ENABLE      0
`define UFC_FC_RX_CLEAR    1
`define UFC_FC_TX_CLEAR    2
`define UFC_FC_DMA_MODE    3
`define UFC_FC_TRIG_LO     6
`define UFC_FC_TRIG_HI     7
`define UFC_FC_RESET       8'h00

`define UFC_TRIG_CODE0     5'h01
`define UFC_TRIG_CODE1     5'h04
`define UFC_TRIG_CODE2     5'h08
`define UFC_TRIG_CODE3     5'h0e

`define UFC_FIFO_DEPTH     16
`define UFC_INT_BITS       4
`define UFC_INT_RX_TRIG    0
`define UFC_INT_TX_SPACE   1
`define UFC_INT_RX_TIMEOUT 2
`define UFC_INT_RX_OVERRUN 3

`define UFC_RESP_OKAY      2'h0
`define UFC_RESP_SLVERR    2'h2

`endif

// [core/ufc_mem.v]
// ufc_mem.v: small character store with registered read data
// assumes one clock; the caller guards writes against full
`timescale 1ns/100ps
module ufc_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock
  input  wire             clock,
  // write side
  input  wire             wrEn,
  input  wire [AW-1:0]    wrAddr,
  input  wire [WIDTH-1:0] wrData,
  // read side
  input  wire [AW-1:0]    rdAddr,
  output reg  [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] store [0:DEPTH-1];

  always @(posedge clock) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end
endmodule // ufc_mem

// [core/ufc_fifo.v]
// ufc_fifo.v: one character fifo with occupancy count and clear
// assumes one clock, async active-high reset; data valid one cycle after pop
`timescale 1ns/100ps
module ufc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst,
  // control
  input  wire             clear,
  // push
  input  wire             push,
  input  wire [WIDTH-1:0] pushData,
  // pop
  input  wire             pop,
  output wire [WIDTH-1:0] popData,
  // state
  output reg  [AW:0]      count_reg,
  output wire             full,
  output wire             empty
);
  reg  [AW-1:0] wrPtr_reg;
  reg  [AW-1:0] rdPtr_reg;
  wire          doPush;
  wire          doPop;

  assign full   = (count_reg == DEPTH[AW:0]);
  assign empty  = (count_reg == {(AW+1){1'b0}});
  assign doPush = push & ~full & ~clear;
  assign doPop  = pop & ~empty & ~clear;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (clear) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPush & ~doPop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (doPop & ~doPush) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  ufc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) uMem (
    .clock  (clock),
    .wrEn   (doPush),
    .wrAddr (wrPtr_reg),
    .wrData (pushData),
    .rdAddr (rdPtr_reg),
    .rdData (popData)
  );
endmodule // ufc_fifo

// [core/ufc_fifo_control.v]
// ufc_fifo_control.v: fifo enable/clear, rx trigger level, dma ready pins,
// block-mode interrupts, axi4-lite register slave
// assumes transmitter and receiver logic on the same clock drive the fifo ports
//
// Function
// - mode 1: transmit interrupt while the tx fifo has any free location
// - mode 1: receive interrupt at trigger level; fifo keeps filling until full
// - receive interrupt raised while stored count is at or above the trigger level; with fifos off it is raised while any character is stored
// - trigger field bits 7:6 pick 1, 4, 8 or 14 bytes
// - control bit 3 picks dma mode 0 (reset) or block mode 1
// - mode 0 or disabled: tx ready low while tx store empty, high once loaded
// - mode 0 or disabled: rx ready low while any character stored
// - mode 1: tx ready high only when tx fifo full
// - mode 1: rx ready low at trigger or timeout, high after fifo empties
// - control bit 2 clears tx fifo and counters, then reads back zero
// - control bit 1 clears rx fifo and counters, then reads back zero
// - control bit 0 enables both fifos; clear after reset
// - other control bits ignored unless the write also sets bit 0
// - receive interrupt drops once occupancy falls below trigger level; with fifos off it stays set until cleared by an interrupt status write
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "ufc_consts.vh"
module ufc_fifo_control #(
  parameter WIDTH = 8,
  parameter DEPTH = `UFC_FIFO_DEPTH,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst,
  // axi4-lite write address
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [3:0]       s_axi_awaddr,
  // axi4-lite write data
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  // axi4-lite write response
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  output reg  [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  input  wire [3:0]       s_axi_araddr,
  // axi4-lite read data
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  // transmit side: host loads, transmitter drains
  input  wire             txLoad,
  input  wire [WIDTH-1:0] txLoadData,
  output wire             txLoadReady,
  input  wire             txTake,
  output wire [WIDTH-1:0] txTakeData,
  output wire             txHasData,
  // receive side: receiver stores, host reads
  input  wire             rxStore,
  input  wire [WIDTH-1:0] rxStoreData,
  input  wire             rxTimeout,
  input  wire             rxRead,
  output wire [WIDTH-1:0] rxReadData,
  output wire             rxHasData,
  // dma pins and interrupt
  output reg              txReady_n,
  output reg              rxReady_n,
  output wire             irq
);
  reg  [7:0]      fifoControl_reg;
  reg  [3:0]      awAddr_reg;
  reg             awHeld_reg;
  reg  [31:0]     wData_reg;
  reg  [3:0]      wStrb_reg;
  reg             wHeld_reg;
  reg             rxDmaLatch_reg;
  reg  [`UFC_INT_BITS-1:0] intStatus_reg;
  reg  [`UFC_INT_BITS-1:0] intMask_reg;
  reg  [`UFC_INT_BITS-1:0] intStatus_next;
  reg  [31:0]     readWord;
  wire            fifoOn;
  wire            blockMode;
  wire [4:0]      trigLevel;
  wire            doWrite;
  wire            ctlWrite;
  wire            txClear;
  wire            rxClear;
  wire [AW:0]     txCount;
  wire [AW:0]     rxCount;
  wire            txFull;
  wire            txEmpty;
  wire            rxFull;
  wire            rxEmpty;
  wire            txDepth;
  wire            rxAtTrig;
  wire            rxAboveTrig;
  wire            rxTrigHit;
  wire            txSpaceEvt;
  wire [`UFC_INT_BITS-1:0] intEvent;

  // trigger code to byte count
  function [4:0] trigDecode;
    input [1:0] code;
    begin
      case (code)
        2'h0: trigDecode = `UFC_TRIG_CODE0;
        2'h1: trigDecode = `UFC_TRIG_CODE1;
        2'h2: trigDecode = `UFC_TRIG_CODE2;
        2'h3: trigDecode = `UFC_TRIG_CODE3;
        default: trigDecode = `UFC_TRIG_CODE0;
      endcase
    end
  endfunction

  assign fifoOn    = fifoControl_reg[`UFC_FC_ENABLE];
  assign blockMode = fifoOn & fifoControl_reg[`UFC_FC_DMA_MODE];
  assign trigLevel = trigDecode(fifoControl_reg[`UFC_FC_TRIG_HI:`UFC_FC_TRIG_LO]);

  // write path: address and data taken in either order, response after both
  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_reg & ~s_axi_bvalid;
  assign doWrite       = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  assign ctlWrite      = doWrite & (awAddr_reg == `UFC_OFF_FIFO_CONTROL) & wStrb_reg[0];

  // clears act for one cycle on the write itself; the stored bits never hold them
  assign txClear = ctlWrite & wData_reg[`UFC_FC_ENABLE] & wData_reg[`UFC_FC_TX_CLEAR];
  assign rxClear = ctlWrite & wData_reg[`UFC_FC_ENABLE] & wData_reg[`UFC_FC_RX_CLEAR];

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld_reg      <= 1'b0;
      awAddr_reg      <= 4'h0;
      wHeld_reg       <= 1'b0;
      wData_reg       <= 32'h0;
      wStrb_reg       <= 4'h0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `UFC_RESP_OKAY;
      fifoControl_reg <= `UFC_FC_RESET;
      intMask_reg     <= {`UFC_INT_BITS{1'b0}};
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `UFC_RESP_OKAY;
        case (awAddr_reg)
          `UFC_OFF_FIFO_CONTROL: begin
            if (wStrb_reg[0]) begin
              if (wData_reg[`UFC_FC_ENABLE]) begin
                // bits 5:4 kept as written; software is expected to write zero
                fifoControl_reg <= {wData_reg[7:3], 2'b00, 1'b1};
              end else begin
                fifoControl_reg[`UFC_FC_ENABLE] <= 1'b0;
              end
            end
          end
          `UFC_OFF_INT_MASK: begin
            if (wStrb_reg[0]) begin
              intMask_reg <= wData_reg[`UFC_INT_BITS-1:0];
            end
          end
          `UFC_OFF_STATUS, `UFC_OFF_INT_STATUS: begin
          end
          default: s_axi_bresp <= `UFC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: one cycle from address to data
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    readWord = 32'h0;
    case (s_axi_araddr)
      `UFC_OFF_FIFO_CONTROL: readWord[7:0] = fifoControl_reg;
      `UFC_OFF_STATUS:
        readWord[15:0] = {rxFull, rxEmpty, txFull, txEmpty, 1'b0, rxCount, 1'b0, txCount};
      `UFC_OFF_INT_STATUS: readWord[`UFC_INT_BITS-1:0] = intStatus_reg;
      `UFC_OFF_INT_MASK:   readWord[`UFC_INT_BITS-1:0] = intMask_reg;
      default:             readWord = 32'h0;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `UFC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readWord;
      case (s_axi_araddr)
        `UFC_OFF_FIFO_CONTROL, `UFC_OFF_STATUS, `UFC_OFF_INT_STATUS, `UFC_OFF_INT_MASK:
          s_axi_rresp <= `UFC_RESP_OKAY;
        default: s_axi_rresp <= `UFC_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // with fifos off each store acts as a single holding register
  assign txDepth     = fifoOn ? txFull : ~txEmpty;
  assign txLoadReady = ~txDepth & ~txClear;
  assign txHasData   = ~txEmpty;
  assign rxHasData   = ~rxEmpty;

  ufc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) uTxFifo (
    .clock     (clock),
    .rst       (rst),
    .clear     (txClear),
    .push      (txLoad & txLoadReady),
    .pushData  (txLoadData),
    .pop       (txTake),
    .popData   (txTakeData),
    .count_reg (txCount),
    .full      (txFull),
    .empty     (txEmpty)
  );

  // receive store accepts past the trigger until full; overrun flagged beyond
  ufc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) uRxFifo (
    .clock     (clock),
    .rst       (rst),
    .clear     (rxClear),
    .push      (rxStore & (fifoOn ? ~rxFull : rxEmpty)),
    .pushData  (rxStoreData),
    .pop       (rxRead),
    .popData   (rxReadData),
    .count_reg (rxCount),
    .full      (rxFull),
    .empty     (rxEmpty)
  );

  assign rxAtTrig    = ({1'b0, rxCount} == {1'b0, trigLevel});
  assign rxAboveTrig = ({1'b0, rxCount} >= {1'b0, trigLevel});
  assign rxTrigHit   = fifoOn & rxAtTrig & rxStore;
  assign txSpaceEvt  = blockMode & ~txFull;

  assign intEvent[`UFC_INT_RX_TRIG]    = fifoOn ? rxAboveTrig : ~rxEmpty;
  assign intEvent[`UFC_INT_TX_SPACE]   = fifoOn ? txSpaceEvt : txEmpty;
  assign intEvent[`UFC_INT_RX_TIMEOUT] = rxTimeout & fifoOn & ~rxEmpty;
  assign intEvent[`UFC_INT_RX_OVERRUN] = rxStore & (fifoOn ? rxFull : ~rxEmpty);

  // sticky status; a new event in the clearing cycle wins
  always @* begin
    intStatus_next = intStatus_reg;
    if (doWrite & (awAddr_reg == `UFC_OFF_INT_STATUS) & wStrb_reg[0]) begin
      intStatus_next = intStatus_reg & ~wData_reg[`UFC_INT_BITS-1:0];
    end
    intStatus_next = intStatus_next | intEvent;
    // level-type receive condition follows the fill level when fifos are on
    if (fifoOn & ~rxAboveTrig & ~rxTrigHit) begin
      intStatus_next[`UFC_INT_RX_TRIG] = 1'b0;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      intStatus_reg <= {`UFC_INT_BITS{1'b0}};
    end else begin
      intStatus_reg <= intStatus_next;
    end
  end

  assign irq = |(intStatus_reg & intMask_reg);

  // dma ready pins
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rxDmaLatch_reg <= 1'b0;
      txReady_n      <= 1'b0;
      rxReady_n      <= 1'b1;
    end else begin
      if (~blockMode | rxClear | (rxEmpty & ~rxStore)) begin
        rxDmaLatch_reg <= 1'b0;
      end else if (rxAboveTrig | rxTimeout) begin
        rxDmaLatch_reg <= 1'b1;
      end
      if (blockMode) begin
        txReady_n <= txFull;
        // the latch drops a cycle after the store empties; mask it with the live flag
        rxReady_n <= ~((rxDmaLatch_reg & ~rxEmpty) | rxAboveTrig | rxTimeout);
      end else begin
        txReady_n <= ~txEmpty;
        rxReady_n <= rxEmpty;
      end
    end
  end
endmodule // ufc_fifo_control

// [verification/ufc_fifo_control_monitor.sv]
// ufc_fifo_control_monitor.sv: port-level checks for the fifo control block
// assumes it is bound into ufc_fifo_control and sees only its ports
`timescale 1ns/100ps
module ufc_fifo_control_monitor (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // fifo state and pins
  input wire        txLoadReady,
  input wire        txHasData,
  input wire        rxTimeout,
  input wire        rxHasData,
  input wire        txReady_n,
  input wire        rxReady_n,
  input wire        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rx_idle_a: assert property (!rxHasData && !rxTimeout |=> rxReady_n)
    else $error("rx ready active with empty store");
  tx_idle_a: assert property (!txHasData |=> !txReady_n)
    else $error("tx ready inactive with empty store");
  tx_full_a: assert property (!txLoadReady && txHasData |=> txReady_n)
    else $error("tx ready active with no room");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($fell(rxReady_n));
  cover property ($rose(txReady_n));
  cover property ($rose(irq));
endmodule // ufc_fifo_control_monitor

bind ufc_fifo_control ufc_fifo_control_monitor mon (.clock(clock), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .txLoadReady(txLoadReady), .txHasData(txHasData), .rxTimeout(rxTimeout),
  .rxHasData(rxHasData), .txReady_n(txReady_n), .rxReady_n(rxReady_n), .irq(irq));

// [verification/ufc_line_model.sv]
// ufc_line_model.sv: behavioural transmitter and receiver beside the fifo block
// assumes the bench steers it and it shares the block's clock
`timescale 1ns/100ps
module ufc_line_model (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // bench control
  input  wire       drain,
  input  wire       slow,
  input  wire       snd,
  input  wire [7:0] sb,
  input  wire       tmo,
  // block side
  input  wire       txHasData,
  output reg        txTake,
  output reg        rxStore,
  output reg  [7:0] rxStoreData,
  output reg        rxTimeout
);
  reg [1:0] div_reg;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg <= 2'h0;
      txTake <= 1'b0;
      rxStore <= 1'b0;
      rxStoreData <= 8'h00;
      rxTimeout <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      // no back-to-back pops: txHasData lags a pop by a cycle
      txTake <= drain && txHasData && !txTake && (!slow || div_reg == 2'h0);
      rxStore <= snd;
      // idle bus keeps moving so a stale byte never looks fresh
      rxStoreData <= snd ? sb : ~rxStoreData;
      rxTimeout <= tmo && !rxTimeout;
    end
  end
endmodule // ufc_line_model

// [verification/tb.sv]
// tb.sv: self-checking bench for the fifo control block
// assumes the line model stands in for transmitter and receiver logic
`timescale 1ns/100ps
module tb;
  logic        clock = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [3:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdv;
  logic        txLoad = 0, rxRead = 0, drain = 0, slow = 0, snd = 0, tmo = 0;
  wire         awr, wrd, bv, arr, rv, tk, rs, rt, tlr, thd, rhd, txReady_n, rxReady_n, irq;
  wire [1:0]   br, rr;
  wire [31:0]  rdat;
  wire [7:0]   rsd, txd, rxd;
  int          fail_count = 0, tests_run = 0;
  ufc_fifo_control dut (.clock(clock), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .s_axi_rdata(rdat), .s_axi_rresp(rr), .txLoad(txLoad),
    .txLoadData(8'h41), .txLoadReady(tlr), .txTake(tk), .txTakeData(txd), .txHasData(thd),
    .rxStore(rs), .rxStoreData(rsd), .rxTimeout(rt), .rxRead(rxRead), .rxReadData(rxd),
    .rxHasData(rhd), .txReady_n(txReady_n), .rxReady_n(rxReady_n), .irq(irq));
  ufc_line_model line (.clock(clock), .rst(rst), .drain(drain), .slow(slow), .snd(snd),
    .sb(8'h5a), .tmo(tmo), .txHasData(thd), .txTake(tk), .rxStore(rs), .rxStoreData(rsd),
    .rxTimeout(rt));
  initial forever #10 clock = ~clock;
  task finish_test;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task bust;
    fail_count++;
    finish_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1;
    pw = 1;
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
      if (pa && awr) begin
        pa = 0;
        awv <= 0;
      end
      if (pw && wrd) begin
        pw = 0;
        wv <= 0;
      end
      // ready held back a cycle so the response has to stand on its own
      if (bv && !bready) bready <= 1;
      if (n > 50) bust();
    end while (!(bv && bready));
    bready <= 0;
    chk(br, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] er = 2'h0);
    int n;
    logic pa;
    n = 0;
    pa = 1;
    arv <= 1;
    ara <= a;
    do begin
      @(posedge clock);
      n++;
      if (pa && arr) begin
        pa = 0;
        arv <= 0;
      end
      if (rv && !rready) rready <= 1;
      if (n > 50) bust();
    end while (!(rv && rready));
    rdv = rdat;
    rready <= 0;
    chk(rr, er);
  endtask
  task st(input int n);
    snd <= 1;
    tick(n);
    snd <= 0;
  endtask
  task pop(input int n);
    rxRead <= 1;
    tick(n);
    rxRead <= 0;
  endtask
  task t_mode0;
    rd(0);
    chk(rdv, 0);
    chk({txReady_n, rxReady_n}, 2'b01);
    wr(0, 8'h01);
    txLoad <= 1;
    tick(1);
    txLoad <= 0;
    tick(3);
    chk(txReady_n, 1);
    chk(thd, 1);
    chk(txd, 8'h41);
    drain <= 1;
    slow <= 1;
    tick(8);
    chk(txReady_n, 0);
    drain <= 0;
    st(1);
    tick(3);
    chk(rxReady_n, 0);
    chk(rhd, 1);
    chk(rxd, 8'h5a);
    pop(1);
    tick(3);
    chk(rxReady_n, 1);
  endtask
  task t_trig;
    int lv;
    for (int c = 0; c < 4; c++) begin
      lv = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 14;
      wr(0, {c[1:0], 6'h0b});
      wr(4'hc, 8'h01);
      if (lv > 1) st(lv - 1);
      tick(3);
      chk({rxReady_n, irq}, 2'b10);
      st(1);
      tick(3);
      chk({rxReady_n, irq}, 2'b01);
      st(2);
      tick(3);
      rd(4);
      chk(rdv[10:6], lv + 2);
      pop(3);
      tick(3);
      chk({rxReady_n, irq}, {lv == 1, 1'b0});
    end
    rd(0);
    chk(rdv, 32'hc9);
  endtask
  task t_tx;
    wr(4'hc, 8'h02);
    tick(2);
    chk(irq, 1);
    txLoad <= 1;
    tick(16);
    txLoad <= 0;
    tick(3);
    chk({tlr, txReady_n}, 2'b01);
    rd(4);
    chk(rdv[4:0], 16);
    wr(8, 8'h02);
    chk(irq, 0);
    wr(0, 8'hcd);
    tick(3);
    chk({txReady_n, irq}, 2'b01);
    rd(0);
    chk(rdv, 32'hc9);
    rd(4);
    chk(rdv[4:0], 0);
  endtask
  task t_tmo;
    wr(0, 8'hcb);
    st(1);
    tick(3);
    chk(rxReady_n, 1);
    tmo <= 1;
    tick(1);
    tmo <= 0;
    tick(3);
    chk(rxReady_n, 0);
    pop(1);
    tick(3);
    chk(rxReady_n, 1);
  endtask
  task t_misc;
    wr(0, 8'h48);
    rd(0);
    chk(rdv, 32'hc8);
    wr(8, 8'h0f);
    wr(4'hc, 8'h08);
    chk(irq, 0);
    st(2);
    tick(3);
    chk({rxReady_n, irq}, 2'b01);
    wr(4'hc, 8'h00);
    chk(irq, 0);
    wr(4'hc, 8'h08);
    chk(irq, 1);
    wr(8, 8'h08);
    chk(irq, 0);
    wr(4'h2, 8'h00, 2'h2);
    rd(4'h2, 2'h2);
    chk(rdv, 0);
  endtask
  initial begin
    tick(4);
    rst <= 0;
    tick(1);
    t_mode0;
    t_trig;
    t_tx;
    t_tmo;
    t_misc;
    finish_test();
  end
endmodule // tb
